// ==== flash_self_pkg.sv ====
// Shared constants and carriers for the program flash self-access controller
package flash_self_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_W        = 3'h3;
    localparam logic [2:0] OFS_ADDR_LOW  = 3'h0;
    localparam logic [2:0] OFS_ADDR_HIGH = 3'h1;
    localparam logic [2:0] OFS_DATA_LOW  = 3'h2;
    localparam logic [2:0] OFS_DATA_HIGH = 3'h3;
    localparam logic [2:0] OFS_CTRL      = 3'h4;
    localparam logic [2:0] OFS_KEY       = 3'h5;

    // Control register bit positions
    localparam int BIT_RD    = 0;
    localparam int BIT_WR    = 1;
    localparam int BIT_WRITE_PERMIT  = 2;
    localparam int BIT_WRITE_ABORT_FLAG = 3;
    localparam int BIT_FREE  = 4;
    localparam int BIT_LWLO  = 5;

    // Geometry
    localparam int WORD_W      = 14;
    localparam int ADDR_BITS   = 9;
    localparam int ROW_WORDS   = 16;
    localparam int LATCH_IDX_W = 4;
    localparam logic [13:0] LATCH_RESET = 14'h3FFF;

    // Unlock key pattern
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Timing: row operation time and forced no-operation cycles
    localparam int CLK_MHZ       = 125;
    localparam int ROW_TIME_US   = 2000;
    localparam int ROW_CYCLES    = ROW_TIME_US * CLK_MHZ;
    localparam int FORCED_NOPS   = 2;
    localparam int READ_DELAY    = 2;

    // Register port request carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Array access command carrier
    typedef struct packed {
        logic                 rd;
        logic                 erase;
        logic                 prog;
        logic [8:0]           addr;
    } array_cmd_s;

    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_GOT55,
        UNL_ARMED
    } unlock_e;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_RD_WAIT,
        OP_NOP,
        OP_ROW,
        OP_DONE
    } op_e;
endpackage

// ==== flash_self_access.sv ====
// Program flash self-access controller: registers, unlock, latches, protection, timing
//
// Functional notes
// - Data pair carries a 14-bit word for reads and writes.
// - Address pair holds a 9-bit word address.
// - High address bit in upper register, low byte in lower; 512 words.
// - Write and erase are timed by an internal counter.
// - Code protect low blocks external programmer reads and writes.
// - Code protect does not restrict self erase or write.
// - Only programmer bulk erase clears code protect, wiping everything.
// - Write-protect field blocks self erase and write of its region.
// - Write protect does not affect programmer access.
// - Software only sets read and write triggers; hardware clears on completion.
// - Write or erase happens only while write permit is set.
// - Write permit clears at power-up.
// - Reset during a write sets the abort flag, readable after reset.
// - Key register is write-only and reads zero.
// - Latches and flash change only after the unlock pattern.
// - Erase works on whole rows only.
// - Latches load only through data pair writes.
// - Rows hold 16 words; there are 16 write latches.
// - Write trigger forces two stall cycles, then row operations stall.
// - Read fetches on second cycle after trigger, data next cycle.
// - Completed program resets all latches to all ones.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module flash_self_access #(
    parameter int ROW_CYCLES = flash_self_pkg::ROW_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        por_event,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        code_protect_n,
    input  wire logic [1:0]  self_write_protect_range,
    input  wire logic        prog_rd_req,
    input  wire logic        prog_wr_req,
    input  wire logic        prog_bulk_erase,
    output logic             prog_refused,
    output logic             cpu_stall,
    output flash_self_pkg::array_cmd_s arr_cmd,
    output logic      [13:0] arr_wdata,
    input  wire logic [13:0] arr_rdata,
    output logic             bulk_erase_go
);
    localparam int CNT_W = $clog2(ROW_CYCLES + 1);

    // Register port request bundle
    flash_self_pkg::reg_req_s req;
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Register storage
    logic [7:0]  addr_low_q, addr_low_d;
    logic        addr_high_q;
    logic [13:0] data_q, data_d;
    logic        rd_q, wr_q, write_permit_q, write_abort_flag_q, free_q, lwlo_q;
    logic [13:0] latch_q [flash_self_pkg::ROW_WORDS];
    flash_self_pkg::unlock_e unl_q, unl_d;
    flash_self_pkg::op_e     op_q, op_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic        pending_q;
    logic        rd_pending_q;

    // Decoded strobes
    wire wr_addr_low  = req.wr && req.addr == flash_self_pkg::OFS_ADDR_LOW;
    wire wr_addr_high = req.wr && req.addr == flash_self_pkg::OFS_ADDR_HIGH;
    wire wr_data_low  = req.wr && req.addr == flash_self_pkg::OFS_DATA_LOW;
    wire wr_data_high = req.wr && req.addr == flash_self_pkg::OFS_DATA_HIGH;
    wire wr_ctrl      = req.wr && req.addr == flash_self_pkg::OFS_CTRL;
    wire wr_key       = req.wr && req.addr == flash_self_pkg::OFS_KEY;
    wire set_rd = wr_ctrl && req.wdata[flash_self_pkg::BIT_RD] && op_q == flash_self_pkg::OP_IDLE;
    wire set_wr = wr_ctrl && req.wdata[flash_self_pkg::BIT_WR] && op_q == flash_self_pkg::OP_IDLE;

    // Word address and protection decode
    wire [8:0] word_addr = {addr_high_q, addr_low_q};
    wire [3:0] latch_idx = word_addr[3:0];
    // Protected regions: 00 all, 01 upper half, 10 upper quarter, 11 none
    wire in_protect = (self_write_protect_range == 2'h0) ||
                      (self_write_protect_range == 2'h1 && word_addr[8]) ||
                      (self_write_protect_range == 2'h2 && word_addr[8:7] == 2'h3);
    wire unlocked = (unl_q == flash_self_pkg::UNL_ARMED);
    // Write runs only with permit, unlock and outside protection; code protect not involved
    wire wr_go = set_wr && write_permit_q && unlocked && !in_protect;
    wire wr_is_row = free_q || !lwlo_q;

    // Unlock detector next state
    always_comb begin
        unl_d = flash_self_pkg::UNL_IDLE;
        case (unl_q)
            flash_self_pkg::UNL_IDLE:
                if (wr_key && req.wdata == flash_self_pkg::KEY_FIRST) begin
                    unl_d = flash_self_pkg::UNL_GOT55;
                end
            flash_self_pkg::UNL_GOT55:
                if (!req.wr && !req.rd) begin
                    unl_d = unl_q;
                end else if (wr_key && req.wdata == flash_self_pkg::KEY_SECOND) begin
                    unl_d = flash_self_pkg::UNL_ARMED;
                end
            flash_self_pkg::UNL_ARMED:
                if (!req.wr && !req.rd) begin
                    unl_d = unl_q;
                end
            default:
                unl_d = flash_self_pkg::UNL_IDLE;
        endcase
    end

    // Operation sequencer: read delay, forced stall cycles, timed row operation
    always_comb begin
        op_d  = op_q;
        cnt_d = cnt_q;
        case (op_q)
            flash_self_pkg::OP_IDLE:
                if (set_rd) begin
                    op_d  = flash_self_pkg::OP_RD_WAIT;
                    cnt_d = CNT_W'(flash_self_pkg::READ_DELAY - 1);
                end else if (wr_go) begin
                    op_d  = flash_self_pkg::OP_NOP;
                    cnt_d = CNT_W'(flash_self_pkg::FORCED_NOPS - 1);
                end
            flash_self_pkg::OP_RD_WAIT:
                if (cnt_q == '0) begin
                    op_d = flash_self_pkg::OP_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            flash_self_pkg::OP_NOP:
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else if (wr_is_row) begin
                    op_d  = flash_self_pkg::OP_ROW;
                    cnt_d = CNT_W'(ROW_CYCLES - 1);
                end else begin
                    op_d = flash_self_pkg::OP_DONE;
                end
            flash_self_pkg::OP_ROW:
                if (cnt_q == '0) begin
                    op_d = flash_self_pkg::OP_DONE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            flash_self_pkg::OP_DONE:
                op_d = flash_self_pkg::OP_IDLE;
            default:
                op_d = flash_self_pkg::OP_IDLE;
        endcase
    end

    wire rd_fetch   = op_q == flash_self_pkg::OP_RD_WAIT && cnt_q == '0;
    wire op_done    = op_q == flash_self_pkg::OP_DONE;
    wire prog_done  = op_done && !free_q && !lwlo_q;
    // Every accepted write trigger (permit, unlock, outside protection) that is not an erase loads the addressed latch first
    wire latch_load = wr_go && !req.wdata[flash_self_pkg::BIT_FREE];
    // Row program streams all latches out in the last row-time cycles
    wire row_prog   = op_q == flash_self_pkg::OP_ROW && !free_q && !lwlo_q &&
                      cnt_q < CNT_W'(flash_self_pkg::ROW_WORDS);
    wire [3:0] prog_slot = cnt_q[3:0];

    // Data pair next value: software bytes or fetched word
    always_comb begin
        data_d = data_q;
        if (rd_pending_q) begin
            data_d = arr_rdata;
        end else if (wr_data_low) begin
            data_d[7:0] = req.wdata;
        end else if (wr_data_high) begin
            data_d[13:8] = req.wdata[5:0];
        end
    end
    assign addr_low_d = wr_addr_low ? req.wdata : addr_low_q;

    // Main state registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            unl_q        <= flash_self_pkg::UNL_IDLE;
            op_q         <= flash_self_pkg::OP_IDLE;
            cnt_q        <= '0;
            addr_low_q   <= '0;
            addr_high_q  <= 1'b0;
            data_q       <= '0;
            rd_pending_q <= 1'b0;
        end else begin
            unl_q        <= unl_d;
            op_q         <= op_d;
            cnt_q        <= cnt_d;
            addr_low_q   <= addr_low_d;
            addr_high_q  <= wr_addr_high ? req.wdata[0] : addr_high_q;
            data_q       <= data_d;
            rd_pending_q <= rd_fetch;
        end
    end

    // Control bits: triggers only set by software, cleared by hardware
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
            write_permit_q <= 1'b0;
            free_q <= 1'b0;
            lwlo_q <= 1'b0;
        end else begin
            rd_q   <= set_rd || (rd_q && !rd_pending_q);
            wr_q   <= wr_go || (wr_q && !op_done);
            write_permit_q <= wr_ctrl ? req.wdata[flash_self_pkg::BIT_WRITE_PERMIT] : write_permit_q;
            free_q <= (wr_ctrl && op_q == flash_self_pkg::OP_IDLE) ? req.wdata[flash_self_pkg::BIT_FREE] : free_q;
            lwlo_q <= (wr_ctrl && op_q == flash_self_pkg::OP_IDLE) ? req.wdata[flash_self_pkg::BIT_LWLO] : lwlo_q;
        end
    end

    // Abort flag: pending write when reset hits; set wins, software writes zero to clear
    // Kept out of reset so it still remembers the running write once reset arrives
    always_ff @(posedge core_clk) begin
        pending_q <= rst_b && wr_q;
    end
    always_ff @(posedge core_clk) begin
        if (por_event) begin
            write_abort_flag_q <= 1'b0;
        end else if (!rst_b && pending_q) begin
            write_abort_flag_q <= 1'b1;
        end else if (rst_b && wr_ctrl && !req.wdata[flash_self_pkg::BIT_WRITE_ABORT_FLAG]) begin
            write_abort_flag_q <= 1'b0;
        end
    end

    // Write latches: loaded from data pair, reset to all ones after a program
    genvar gi;
    generate
        for (gi = 0; gi < flash_self_pkg::ROW_WORDS; gi++) begin : g_latch
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    latch_q[gi] <= flash_self_pkg::LATCH_RESET;
                end else if (prog_done || prog_bulk_erase) begin
                    latch_q[gi] <= flash_self_pkg::LATCH_RESET;
                end else if (latch_load && latch_idx == 4'(gi)) begin
                    latch_q[gi] <= data_q;
                end
            end
        end
    endgenerate

    // Array command: read, row erase at row base, row program
    assign arr_cmd.rd    = rd_fetch;
    assign arr_cmd.erase = op_done && free_q;
    assign arr_cmd.prog  = row_prog;
    assign arr_cmd.addr  = arr_cmd.erase ? {word_addr[8:4], 4'h0} :
                           row_prog      ? {word_addr[8:4], prog_slot} : word_addr;
    assign arr_wdata     = latch_q[prog_slot];

    // Programmer side: code protect gates reads and writes, write protect ignored
    assign prog_refused  = !code_protect_n && (prog_rd_req || prog_wr_req);
    assign bulk_erase_go = prog_bulk_erase;
    assign cpu_stall     = op_q == flash_self_pkg::OP_NOP || op_q == flash_self_pkg::OP_ROW;

    // Read mux; key register reads zero
    logic [7:0] rdata_q;
    wire [7:0] ctrl_rd = {2'h0, lwlo_q, free_q, write_abort_flag_q, write_permit_q, wr_q, rd_q};
    wire [7:0] rd_mux  = req.addr == flash_self_pkg::OFS_ADDR_LOW  ? addr_low_q :
                         req.addr == flash_self_pkg::OFS_ADDR_HIGH ? {7'h00, addr_high_q} :
                         req.addr == flash_self_pkg::OFS_DATA_LOW  ? data_q[7:0] :
                         req.addr == flash_self_pkg::OFS_DATA_HIGH ? {2'h0, data_q[13:8]} :
                         req.addr == flash_self_pkg::OFS_CTRL      ? ctrl_rd : 8'h00;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= req.rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // Checks
    a_wr_needs_permit: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_go |-> write_permit_q && unlocked) else $error("write started without permit");
    a_protect_blocks: assert property (@(posedge core_clk) disable iff (!rst_b)
        set_wr && in_protect |=> !wr_q) else $error("protected write accepted");
    a_key_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.rd && req.addr == flash_self_pkg::OFS_KEY |=> reg_rdata == 8'h00) else $error("key read nonzero");
    a_read_timing: assert property (@(posedge core_clk) disable iff (!rst_b)
        set_rd |=> ##1 rd_fetch ##2 data_q == $past(arr_rdata)) else $error("read timing wrong");
    a_forced_nops: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_go |=> cpu_stall [*2]) else $error("missing stall cycles");
    a_rd_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        rd_q && !rd_pending_q |=> rd_q) else $error("read trigger dropped early");
    a_latch_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
        prog_done |=> latch_q[0] == flash_self_pkg::LATCH_RESET) else $error("latch not reset");
    a_unlock_abort: assert property (@(posedge core_clk) disable iff (!rst_b)
        unl_q == flash_self_pkg::UNL_GOT55 && req.rd |=> unl_q == flash_self_pkg::UNL_IDLE)
        else $error("unlock not aborted");
    a_cp_refuse: assert property (@(posedge core_clk) disable iff (!rst_b)
        !code_protect_n && prog_rd_req |-> prog_refused) else $error("protected read allowed");
    c_read: cover property (@(posedge core_clk) disable iff (!rst_b) rd_fetch);
    c_erase: cover property (@(posedge core_clk) disable iff (!rst_b) arr_cmd.erase);
    c_program: cover property (@(posedge core_clk) disable iff (!rst_b) prog_done);
endmodule

// ==== flash_array_model.sv ====
// Behavioural flash array that sits on the far side of the self-access controller
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic                       core_clk,
    input  wire flash_self_pkg::array_cmd_s arr_cmd,
    input  wire logic [13:0]                arr_wdata,
    output logic      [13:0]                arr_rdata
);
    logic [13:0] mem [512];
    logic [13:0] last_q;
    logic        hold_q;

    // Power-on contents follow an address pattern that the bench also knows
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 14'(i * 37 + 5);
        end
        last_q = 14'h0000;
        hold_q = 1'b0;
    end

    // Read data stands in the fetch cycle and the one after, then the bus flips
    assign arr_rdata = arr_cmd.rd ? mem[arr_cmd.addr] : (hold_q ? last_q : ~last_q);

    // Erase clears a whole row; programming can only pull bits low
    always @(posedge core_clk) begin
        hold_q <= arr_cmd.rd;
        if (arr_cmd.rd) begin
            last_q <= mem[arr_cmd.addr];
        end
        if (arr_cmd.erase) begin
            for (int i = 0; i < 16; i++) begin
                mem[{arr_cmd.addr[8:4], 4'(i)}] <= 14'h3FFF;
            end
        end
        if (arr_cmd.prog) begin
            mem[arr_cmd.addr] <= mem[arr_cmd.addr] & arr_wdata;
        end
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the program flash self-access controller
`timescale 1ns/1ps
module tb;
    localparam int         ROWC = 20;
    localparam logic [2:0] CTL  = flash_self_pkg::OFS_CTRL;
    localparam logic [2:0] KEY  = flash_self_pkg::OFS_KEY;
    logic                       core_clk = 1'b0;
    logic                       rst_b = 1'b0;
    logic                       por_event = 1'b1;
    logic [2:0]                 reg_addr = 3'h0;
    logic [7:0]                 reg_wdata = 8'h00;
    logic                       reg_wr = 1'b0;
    logic                       reg_rd = 1'b0;
    logic [7:0]                 reg_rdata;
    logic                       code_protect_n = 1'b1;
    logic [1:0]                 self_write_protect_range = 2'h3;
    logic                       prog_rd_req = 1'b0;
    logic                       prog_wr_req = 1'b0;
    logic                       prog_bulk_erase = 1'b0;
    logic                       prog_refused;
    logic                       cpu_stall;
    flash_self_pkg::array_cmd_s arr_cmd;
    logic [13:0]                arr_wdata;
    logic [13:0]                arr_rdata;
    logic                       bulk_erase_go;
    logic [13:0]                shadow [512];
    logic [8:0]                 edges [4] = '{9'h0F0, 9'h100, 9'h170, 9'h180};
    int                         seed = 80932;
    int                         fail_count = 0;
    int                         compares = 0;

    flash_self_access #(.ROW_CYCLES(ROWC)) flash_self_access_inst (
        .core_clk(core_clk), .rst_b(rst_b), .por_event(por_event), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .code_protect_n(code_protect_n), .self_write_protect_range(self_write_protect_range),
        .prog_rd_req(prog_rd_req), .prog_wr_req(prog_wr_req), .prog_bulk_erase(prog_bulk_erase),
        .prog_refused(prog_refused), .cpu_stall(cpu_stall), .arr_cmd(arr_cmd),
        .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .bulk_erase_go(bulk_erase_go));
    flash_array_model flash_array_model_inst (
        .core_clk(core_clk), .arr_cmd(arr_cmd), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));

    // Clock toggles every half period of 4 ns
    always #4 core_clk = ~core_clk;

    task automatic close_out();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register port cycles: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic set_addr(input logic [8:0] a);
        wr(flash_self_pkg::OFS_ADDR_LOW, a[7:0]);
        wr(flash_self_pkg::OFS_ADDR_HIGH, {7'h00, a[8]});
    endtask

    task automatic put(input logic [13:0] w);
        wr(flash_self_pkg::OFS_DATA_LOW, w[7:0]);
        wr(flash_self_pkg::OFS_DATA_HIGH, {2'h0, w[13:8]});
    endtask

    // Word fetch through the data pair, compared with the expected array
    task automatic fetch(input logic [8:0] a);
        logic [7:0] lo;
        logic [7:0] hi;
        set_addr(a);
        wr(CTL, 8'h01);
        repeat (3) @(posedge core_clk);
        rd(flash_self_pkg::OFS_DATA_LOW, lo);
        rd(flash_self_pkg::OFS_DATA_HIGH, hi);
        check({hi[5:0], lo}, shadow[a]);
        rd(CTL, lo);
        check(lo[1:0], 2'h0);
    endtask

    // Unlock and trigger; optionally break the sequence or reset mid-operation
    task automatic launch(input logic [8:0] a, input logic [7:0] c, input logic [7:0] k2,
                          input logic brk, input logic abrt, output int n);
        logic [7:0] v;
        set_addr(a);
        wr(CTL, c);
        wr(KEY, 8'h55);
        if (brk) begin
            rd(KEY, v);
            check(v, 8'h00);
        end
        wr(KEY, k2);
        wr(CTL, c | 8'h02);
        n = 0;
        #1;
        if (abrt) begin
            repeat (5) @(posedge core_clk);
            rst_b <= 1'b0;
            repeat (2) @(posedge core_clk);
            rst_b <= 1'b1;
        end
        while (cpu_stall === 1'b1 && n < 1000) begin
            n++;
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic clear_row(input logic [8:0] a);
        for (int i = 0; i < 16; i++) begin
            shadow[{a[8:4], 4'(i)}] = 14'h3FFF;
        end
    endtask

    // Main sequence
    initial begin
        logic [7:0]  v;
        logic [13:0] w;
        logic [8:0]  a;
        int          n;
        logic        prot;
        for (int i = 0; i < 512; i++) begin
            shadow[i] = 14'(i * 37 + 5);
        end
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        por_event <= 1'b0;
        rd(CTL, v);
        check(v[3:0], 4'h0);
        set_addr(9'h1A5);
        wr(3'h6, 8'hFF);
        rd(flash_self_pkg::OFS_ADDR_LOW, v);
        check(v, 8'hA5);
        rd(flash_self_pkg::OFS_ADDR_HIGH, v);
        check(v[0], 1'b1);
        for (int i = 0; i < 8; i++) begin
            fetch(9'($random(seed)));
        end
        // Refused triggers: no permit, wrong key, interrupted sequence
        a = {5'($random(seed)), 4'h0};
        launch(a, 8'h10, 8'hAA, 1'b0, 1'b0, n);
        fetch(a);
        launch(a, 8'h14, 8'hA5, 1'b0, 1'b0, n);
        fetch(a);
        launch(a, 8'h14, 8'hAA, 1'b1, 1'b0, n);
        fetch(a);
        // Row erase while code protected, from a mid-row address
        code_protect_n <= 1'b0;
        launch(a + 9'h3, 8'h14, 8'hAA, 1'b0, 1'b0, n);
        check(14'(n), 14'(2 + ROWC));
        clear_row(a);
        fetch(a + 9'hF);
        fetch(a + 9'h10);
        code_protect_n <= 1'b1;
        // Every protect range against rows on both sides of its boundaries
        for (int r = 0; r < 4; r++) begin
            self_write_protect_range <= 2'(r);
            for (int k = 0; k < 4; k++) begin
                prot = (r == 0) || (r == 1 && edges[k][8]) || (r == 2 && edges[k][8] && edges[k][7]);
                launch(edges[k], 8'h14, 8'hAA, 1'b0, 1'b0, n);
                if (!prot) begin
                    clear_row(edges[k]);
                end
                fetch(edges[k] + 9'h1);
            end
        end
        // Latch load, then row program, then read both words back
        a = {5'($random(seed)), 4'h0};
        launch(a, 8'h14, 8'hAA, 1'b0, 1'b0, n);
        clear_row(a);
        w = 14'($random(seed));
        put(w);
        launch(a, 8'h24, 8'hAA, 1'b0, 1'b0, n);
        check(14'(n), 14'(2));
        shadow[a] = w;
        w = 14'($random(seed));
        put(w);
        launch(a + 9'h1, 8'h04, 8'hAA, 1'b0, 1'b0, n);
        check(14'(n), 14'(2 + ROWC));
        shadow[a + 9'h1] = w;
        fetch(a);
        fetch(a + 9'h1);
        fetch(a + 9'h2);
        // External programmer access under code and write protection
        @(posedge core_clk);
        code_protect_n <= 1'b0;
        prog_wr_req <= 1'b1;
        #1 check(prog_refused, 1'b1);
        @(posedge core_clk);
        code_protect_n <= 1'b1;
        self_write_protect_range <= 2'h0;
        #1 check(prog_refused, 1'b0);
        @(posedge core_clk);
        prog_wr_req <= 1'b0;
        prog_rd_req <= 1'b1;
        code_protect_n <= 1'b0;
        prog_bulk_erase <= 1'b1;
        #1 check({prog_refused, bulk_erase_go}, 2'h3);
        @(posedge core_clk);
        prog_rd_req <= 1'b0;
        prog_bulk_erase <= 1'b0;
        code_protect_n <= 1'b1;
        self_write_protect_range <= 2'h3;
        #1 check(bulk_erase_go, 1'b0);
        // Reset in mid-erase leaves the abort flag readable
        launch(9'h1F0, 8'h14, 8'hAA, 1'b0, 1'b1, n);
        rd(CTL, v);
        check(v[3], 1'b1);
        wr(CTL, 8'h00);
        rd(CTL, v);
        check(v[3], 1'b0);
        close_out();
    end

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        close_out();
    end
endmodule
